// >>> fhc_pkg.sv
/*
 * Shared constants of the floppy host command interface.
 * Assumes a single 250 MHz clock domain and an APB register port.
 */
package fhc_pkg;
   // -------------------------------------------------------------
   // Register map (byte addresses)
   // -------------------------------------------------------------
   localparam logic [7:0] ADDR_STATE   = 8'h00;
   localparam logic [7:0] ADDR_OPER    = 8'h04;
   localparam logic [7:0] ADDR_SKEW    = 8'h08;
   localparam logic [7:0] ADDR_TABLE   = 8'h40;
   localparam logic [7:0] ADDR_TBL_END = 8'h7C;
   // -------------------------------------------------------------
   // Command byte and command string layout
   // -------------------------------------------------------------
   localparam logic [3:0] CMD_STRING   = 4'h1;
   localparam logic [2:0] STR_OPCODE   = 3'h0;
   localparam logic [2:0] STR_STATUS   = 3'h1;
   localparam logic [2:0] STR_CYL      = 3'h2;
   localparam logic [2:0] STR_REC      = 3'h3;
   localparam logic [2:0] STR_PTR_LO   = 3'h4;
   localparam logic [2:0] STR_PTR_HI   = 3'h5;
   localparam int         PHYS_BIT     = 3;
   localparam logic [7:0] OP_MASK      = 8'hF0;
   localparam logic [3:0] OP_MAX       = 4'h5;
   localparam logic [3:0] OP_RESTORE   = 4'hF;
   localparam logic [7:0] REC_MIN      = 8'h01;
   localparam logic [7:0] REC_MAX      = 8'h1A;
   localparam logic [3:0] RETRY_MAX    = 4'hA;
   // -------------------------------------------------------------
   // Status codes written back to host memory (never zero)
   // -------------------------------------------------------------
   localparam logic [7:0] ST_OK        = 8'h01;
   localparam logic [7:0] ST_HW_FAIL   = 8'h02;
   localparam logic [7:0] ST_NOT_READY = 8'h03;
   localparam logic [7:0] ST_BAD_ARG   = 8'h04;
   // -------------------------------------------------------------
   // Head state flag
   // -------------------------------------------------------------
   localparam logic [1:0] HEAD_RAISED  = 2'h0;
   localparam logic [1:0] HEAD_LOWERED = 2'h1;
   localparam logic [1:0] HEAD_PENDING = 2'h2;
   // Default table base, value arbitrary
   localparam logic [15:0] TBL_DEFAULT = 16'h0100;
   localparam logic [15:0] TBL_STRIDE  = 16'h0010;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_FETCH   = 3'b001,
      ST_CHECK   = 3'b010,
      ST_RESTORE = 3'b011,
      ST_EXEC    = 3'b100,
      ST_REPORT  = 3'b101
   } fhc_state_type;
endpackage

// >>> fhc_ctrl.sv
/*
 * Floppy host command interface: command port with host wait,
 * memory master for command strings, data and status, retry and
 * head supervision, APB register slave.
 * Assumes a disk engine beside it that performs one operation per
 * start pulse and requests data bytes while it runs.
 */
// The register offsets and the APB interface to the registers were decided locally.
// Contract
// - Host commands arrive only through the single-byte command port.
// - Strings, data and status move through this block's memory master.
// - Interrupt request rises when the non-zero status byte is written.
// - Any accepted command drops the interrupt request.
// - Unknown command codes do nothing except clear the interrupt.
// - Host waits until the command is taken and processing started.
// - Single-byte completion is shown only by readiness for the next.
// - String completion is shown by a status write into host memory.
// - Status sits at string byte one; a two-byte pointer holds it.
// - A 32-byte pointer table with defaults, writable by the host.
// - A two-byte transfer pointer sources or sinks data bytes.
// - Record index is valid only from 1 to 26.
// - Operation is the upper nibble, 0 to 5, track kind removed.
// - Errors retry up to ten times before a failure is reported (a restore error is reported at once, no retry).
// - Drive going not-ready mid-operation is fatal, no retry.
// - Head flag 0 raised, 1 lowered, 2 pending; raise after a turn (a hardware failure leaves it at 1, lowered).
// - Recovery is internal; any reported hardware error is final.
// - Drives that drop out are restored before their next use.
// - Logical and physical cylinders are kept separately.
module fhc_ctrl
   import fhc_pkg::*;
#(
   parameter int REV_CYCLES = 50000
) (
   input  wire logic        i_mclk,
   input  wire logic        i_srst,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic             o_pready,
   output logic [31:0]      o_prdata,
   output logic             o_pslverr,
   input  wire logic        i_cmd_wr,
   input  wire logic [7:0]  i_cmd_data,
   output logic             o_cmd_accept,
   output logic             o_irq,
   output logic             o_dma_req,
   output logic             o_dma_we,
   output logic [15:0]      o_dma_addr,
   output logic [7:0]       o_dma_wdata,
   input  wire logic        i_dma_ack,
   input  wire logic [7:0]  i_dma_rdata,
   output logic             o_disk_start,
   output logic [3:0]       o_disk_op,
   output logic [7:0]       o_disk_cyl,
   output logic [7:0]       o_disk_rec,
   output logic             o_head_load,
   input  wire logic        i_disk_done,
   input  wire logic        i_disk_err,
   input  wire logic        i_drive_ready,
   input  wire logic        i_xfer_req,
   input  wire logic        i_xfer_we,
   input  wire logic [7:0]  i_xfer_wdata,
   output logic             o_xfer_ack,
   output logic [7:0]       o_xfer_rdata
);
   // -------------------------------------------------------------
   // State
   // -------------------------------------------------------------
   fhc_state_type state_q;
   logic [15:0]   table_q [16];
   logic [15:0]   base_q;
   logic [15:0]   status_ptr_q;
   logic [15:0]   xfer_ptr_q;
   logic [7:0]    op_code_q;
   logic          phys_q;
   logic [7:0]    log_cyl_q;
   logic [7:0]    phys_cyl_q;
   logic [7:0]    rec_q;
   logic [7:0]    skew_q;
   logic [7:0]    stat_q;
   logic [3:0]    retry_q;
   logic [2:0]    idx_q;
   logic [1:0]    head_q;
   logic          head_load_q;
   logic [31:0]   rev_cnt_q;
   logic          restore_q;
   logic          ready_q;
   logic          accept_q;
   logic          irq_q;
   logic          dma_req_q;
   logic          dma_we_q;
   logic [15:0]   dma_addr_q;
   logic [7:0]    dma_wdata_q;
   logic          start_q;
   logic [3:0]    disk_op_q;
   logic          xack_q;
   logic [7:0]    xdata_q;
   logic          pready_q;
   logic [31:0]   prdata_q;
   logic          pslverr_q;

   // Table index of an APB address
   function automatic logic [3:0] tbl_index(input logic [7:0] a);
      return a[5:2];
   endfunction

   // -------------------------------------------------------------
   // Decode
   // -------------------------------------------------------------
   wire       take_cmd  = (state_q == ST_IDLE) && i_cmd_wr && !accept_q;
   wire       cmd_str   = (i_cmd_data[7:4] == CMD_STRING);
   wire       dma_done  = dma_req_q && i_dma_ack;
   wire [3:0] op_field  = op_code_q[7:4];
   wire       bad_arg   = (op_field > OP_MAX) || (rec_q < REC_MIN)
                          || (rec_q > REC_MAX);
   wire       drop_out  = ready_q && !i_drive_ready;
   wire       rev_done  = (rev_cnt_q == 32'(REV_CYCLES - 1));
   wire       apb_acc   = i_psel && i_penable && !pready_q;
   wire       in_table  = (i_paddr >= ADDR_TABLE) && (i_paddr <= ADDR_TBL_END)
                          && (i_paddr[1:0] == 2'b00);
   wire       mapped    = in_table || (i_paddr == ADDR_STATE)
                          || (i_paddr == ADDR_OPER) || (i_paddr == ADDR_SKEW);
   wire [2:0] idx_next  = (idx_q == STR_OPCODE) ? STR_CYL : idx_q + 3'h1;
   wire [15:0] pend_ptr = table_q[i_cmd_data[3:0]];

   // Read data selection
   wire [31:0] rd_mux =
      (i_paddr == ADDR_STATE) ? {16'h0, restore_q, irq_q, head_q,
                                 retry_q, stat_q} :
      (i_paddr == ADDR_OPER)  ? {op_code_q, phys_cyl_q, log_cyl_q, rec_q} :
      (i_paddr == ADDR_SKEW)  ? {24'h0, skew_q} :
      in_table                ? {16'h0, table_q[tbl_index(i_paddr)]} :
                                32'h0;

   // -------------------------------------------------------------
   // APB slave, one wait cycle per access
   // -------------------------------------------------------------
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         pready_q  <= 1'b0;
         prdata_q  <= 32'h0;
         pslverr_q <= 1'b0;
         skew_q    <= 8'h00;
      end else begin
         pready_q  <= apb_acc;
         pslverr_q <= apb_acc && !mapped;
         prdata_q  <= (apb_acc && !i_pwrite) ? rd_mux : 32'h0;
         if (apb_acc && i_pwrite && i_paddr == ADDR_SKEW)
            skew_q <= i_pwdata[7:0];
      end
   end

   // Pointer table with defaults, host writable
   always_ff @(posedge i_mclk) begin
      for (int i = 0; i < 16; i++) begin
         if (i_srst)
            table_q[i] <= TBL_DEFAULT + 16'(i) * TBL_STRIDE;
         else if (apb_acc && i_pwrite && in_table && tbl_index(i_paddr) == 4'(i))
            table_q[i] <= i_pwdata[15:0];
      end
   end

   // -------------------------------------------------------------
   // Command port and interrupt
   // -------------------------------------------------------------
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         accept_q <= 1'b0;
         irq_q    <= 1'b0;
      end else begin
         accept_q <= take_cmd;
         if (state_q == ST_REPORT && dma_done)
            irq_q <= 1'b1;
         else if (take_cmd)
            irq_q <= 1'b0;
      end
   end

   // Head flag and revolution timer
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         head_q      <= HEAD_RAISED;
         head_load_q <= 1'b0;
         rev_cnt_q   <= 32'h0;
      end else if (start_q) begin
         head_q      <= HEAD_LOWERED;
         head_load_q <= 1'b1;
         rev_cnt_q   <= 32'h0;
      end else if (state_q == ST_EXEC && (i_disk_done || drop_out)) begin
         head_q      <= HEAD_PENDING;
         head_load_q <= 1'b1;
      end else if (head_q == HEAD_PENDING) begin
         rev_cnt_q <= rev_cnt_q + 32'h1;
         if (rev_done) begin
            head_q      <= HEAD_RAISED;
            head_load_q <= 1'b0;
         end
      end
   end

   // Drive readiness tracking and restore request
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         ready_q   <= 1'b0;
         restore_q <= 1'b1;
      end else begin
         ready_q <= i_drive_ready;
         if (!i_drive_ready)
            restore_q <= 1'b1;
         else if (state_q == ST_RESTORE && i_disk_done)
            restore_q <= 1'b0;
      end
   end

   // -------------------------------------------------------------
   // Sequencer
   // -------------------------------------------------------------
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         state_q      <= ST_IDLE;
         base_q       <= 16'h0;
         status_ptr_q <= 16'h0;
         xfer_ptr_q   <= 16'h0;
         op_code_q    <= 8'h0;
         phys_q       <= 1'b0;
         log_cyl_q    <= 8'h0;
         phys_cyl_q   <= 8'h0;
         rec_q        <= 8'h0;
         stat_q       <= 8'h0;
         retry_q      <= 4'h0;
         idx_q        <= STR_OPCODE;
         dma_req_q    <= 1'b0;
         dma_we_q     <= 1'b0;
         dma_addr_q   <= 16'h0;
         dma_wdata_q  <= 8'h0;
         start_q      <= 1'b0;
         disk_op_q    <= 4'h0;
         xack_q       <= 1'b0;
         xdata_q      <= 8'h0;
      end else begin
         start_q <= 1'b0;
         xack_q  <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (take_cmd && cmd_str) begin
                  base_q       <= pend_ptr;
                  status_ptr_q <= pend_ptr + 16'(STR_STATUS);
                  idx_q        <= STR_OPCODE;
                  retry_q      <= 4'h0;
                  dma_req_q    <= 1'b1;
                  dma_we_q     <= 1'b0;
                  dma_addr_q   <= pend_ptr;
                  state_q      <= ST_FETCH;
               end
            end
            ST_FETCH: begin
               if (dma_done) begin
                  case (idx_q)
                     STR_OPCODE: begin
                        op_code_q <= i_dma_rdata & OP_MASK;
                        phys_q    <= i_dma_rdata[PHYS_BIT];
                     end
                     STR_CYL:    log_cyl_q <= i_dma_rdata;
                     STR_REC:    rec_q <= i_dma_rdata;
                     STR_PTR_LO: xfer_ptr_q[7:0] <= i_dma_rdata;
                     default:    xfer_ptr_q[15:8] <= i_dma_rdata;
                  endcase
                  idx_q      <= idx_next;
                  dma_addr_q <= base_q + 16'(idx_next);
                  if (idx_q == STR_PTR_HI) begin
                     dma_req_q <= 1'b0;
                     state_q   <= ST_CHECK;
                  end
               end
            end
            ST_CHECK: begin
               phys_cyl_q <= phys_q ? log_cyl_q : log_cyl_q + skew_q;
               if (bad_arg) begin
                  stat_q  <= ST_BAD_ARG;
                  state_q <= ST_REPORT;
               end else if (!i_drive_ready) begin
                  stat_q  <= ST_NOT_READY;
                  state_q <= ST_REPORT;
               end else if (restore_q) begin
                  disk_op_q <= OP_RESTORE;
                  start_q   <= 1'b1;
                  state_q   <= ST_RESTORE;
               end else begin
                  disk_op_q <= op_field;
                  start_q   <= 1'b1;
                  state_q   <= ST_EXEC;
               end
            end
            ST_RESTORE: begin
               if (i_disk_err || !i_drive_ready) begin
                  stat_q  <= ST_HW_FAIL;
                  state_q <= ST_REPORT;
               end else if (i_disk_done) begin
                  disk_op_q <= op_field;
                  start_q   <= 1'b1;
                  state_q   <= ST_EXEC;
               end
            end
            ST_EXEC: begin
               if (dma_done) begin
                  dma_req_q  <= 1'b0;
                  xack_q     <= 1'b1;
                  xdata_q    <= i_dma_rdata;
                  xfer_ptr_q <= xfer_ptr_q + 16'h1;
               end else if (!dma_req_q && !xack_q && i_xfer_req) begin
                  dma_req_q   <= 1'b1;
                  dma_we_q    <= i_xfer_we;
                  dma_addr_q  <= xfer_ptr_q;
                  dma_wdata_q <= i_xfer_wdata;
               end
               if (drop_out) begin
                  stat_q  <= ST_NOT_READY;
                  state_q <= ST_REPORT;
               end else if (i_disk_err) begin
                  if (retry_q == RETRY_MAX) begin
                     stat_q  <= ST_HW_FAIL;
                     state_q <= ST_REPORT;
                  end else begin
                     retry_q <= retry_q + 4'h1;
                     start_q <= 1'b1;
                  end
               end else if (i_disk_done) begin
                  stat_q  <= ST_OK;
                  state_q <= ST_REPORT;
               end
            end
            ST_REPORT: begin
               if (dma_done) begin
                  dma_req_q <= 1'b0;
                  state_q   <= ST_IDLE;
               end else if (!dma_req_q) begin
                  dma_req_q   <= 1'b1;
                  dma_we_q    <= 1'b1;
                  dma_addr_q  <= status_ptr_q;
                  dma_wdata_q <= stat_q;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // -------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------
   assign o_pready     = pready_q;
   assign o_prdata     = prdata_q;
   assign o_pslverr    = pslverr_q;
   assign o_cmd_accept = accept_q;
   assign o_irq        = irq_q;
   assign o_dma_req    = dma_req_q;
   assign o_dma_we     = dma_we_q;
   assign o_dma_addr   = dma_addr_q;
   assign o_dma_wdata  = dma_wdata_q;
   assign o_disk_start = start_q;
   assign o_disk_op    = disk_op_q;
   assign o_disk_cyl   = phys_cyl_q;
   assign o_disk_rec   = rec_q;
   assign o_head_load  = head_load_q;
   assign o_xfer_ack   = xack_q;
   assign o_xfer_rdata = xdata_q;

   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_srst);

   sequence s_status_write;
      state_q == ST_REPORT && dma_done;
   endsequence

   a_irq_raise: assert property (s_status_write |=> irq_q && state_q == ST_IDLE)
      else $error("irq not raised on status write");
   a_irq_drop: assert property (take_cmd |=> !irq_q && accept_q)
      else $error("irq not cleared on accept");
   a_nop_cmd: assert property (take_cmd && !cmd_str |=> state_q == ST_IDLE)
      else $error("unknown command started work");
   a_status_nonzero: assert property (dma_req_q && dma_we_q && state_q == ST_REPORT
      |-> dma_wdata_q != 8'h00 && dma_addr_q == base_q + 16'h1)
      else $error("bad status write");
   a_dma_hold: assert property (dma_req_q && !i_dma_ack |=> dma_req_q && $stable(dma_addr_q))
      else $error("memory request dropped");
   a_arg_range: assert property (start_q && state_q == ST_EXEC
      |-> rec_q >= REC_MIN && rec_q <= REC_MAX && op_field <= OP_MAX)
      else $error("bad argument executed");
   a_retry_limit: assert property (retry_q <= RETRY_MAX)
      else $error("retry counter overran");
   a_fatal_drop: assert property (state_q == ST_EXEC && drop_out
      |=> state_q == ST_REPORT && stat_q == ST_NOT_READY)
      else $error("drop out not fatal");
   a_head_raise: assert property (head_q == HEAD_PENDING && rev_done && !start_q
      |=> head_q == HEAD_RAISED)
      else $error("head not raised after a turn");
   a_accept_pulse: assert property (accept_q |=> !accept_q)
      else $error("accept longer than one cycle");
endmodule // fhc_ctrl

// >>> fhc_host_mem.sv
/*
 * Host memory model answering the block's memory master.
 * Assumes each request is held with its address until acknowledged.
 */
module fhc_host_mem (
   input  wire logic        i_mclk,
   input  wire logic        i_dma_req,
   input  wire logic        i_dma_we,
   input  wire logic [15:0] i_dma_addr,
   input  wire logic [7:0]  i_dma_wdata,
   output logic             o_dma_ack,
   output logic [7:0]       o_dma_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [0:511];
   logic [1:0] wait_q = 2'h0;
   logic       slow_q = 1'b0;
   initial o_dma_ack = 1'b0;
   initial o_dma_rdata = 8'h00;
   // -------------------------------------------------------------
   // Acknowledge after 0 or 3 cycles in turn
   // -------------------------------------------------------------
   always @(posedge i_mclk) begin
      o_dma_ack   <= 1'b0;
      o_dma_rdata <= ~o_dma_rdata; // Stale data never repeats
      if (i_dma_req && !o_dma_ack) begin
         if (wait_q == {slow_q, slow_q}) begin
            o_dma_ack <= 1'b1;
            wait_q    <= 2'h0;
            slow_q    <= ~slow_q;
            if (i_dma_we) begin
               mem[i_dma_addr[8:0]] <= i_dma_wdata;
            end else begin
               o_dma_rdata <= mem[i_dma_addr[8:0]];
            end
         end else begin
            wait_q <= wait_q + 2'h1;
         end
      end
   end
endmodule // fhc_host_mem

// >>> tb_floppy_host_command_interface.sv
/*
 * Self-checking bench: APB registers, command port, strings, retries.
 * Assumes fhc_ctrl, fhc_pkg and the host memory model beside it.
 */
module tb_floppy_host_command_interface;
   import fhc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;
   } fhc_row_type;
   typedef struct packed {
      logic [7:0] op; logic [7:0] rec; logic [7:0] st; logic [7:0] cyl;
   } fhc_arg_type;
   localparam int LIM = 200;
   fhc_row_type rows [7] = '{
      '{1'b0, ADDR_STATE, 32'h0, 32'h0000_8000, 1'b0},
      '{1'b0, ADDR_TABLE, 32'h0, 32'h0000_0100, 1'b0},
      '{1'b0, ADDR_TBL_END, 32'h0, 32'h0000_01F0, 1'b0},
      '{1'b1, 8'h48, 32'h0000_0180, 32'h0, 1'b0},
      '{1'b0, 8'h48, 32'h0, 32'h0000_0180, 1'b0},
      '{1'b1, ADDR_SKEW, 32'h0000_0005, 32'h0, 1'b0},
      '{1'b0, 8'h20, 32'h0, 32'h0, 1'b1}};
   fhc_arg_type args [5] = '{
      '{8'h00, REC_MAX, ST_OK, 8'h08}, '{8'h58, REC_MIN, ST_OK, 8'h03},
      '{8'h00, 8'h00, ST_BAD_ARG, 8'h00}, '{8'h00, 8'h1B, ST_BAD_ARG, 8'h00},
      '{8'h60, REC_MIN, ST_BAD_ARG, 8'h00}};
   logic clk, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, cmd_data = 8'h00, disk_cyl, disk_rec, dma_wdata, dma_rdata;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, cmd_wr = 1'b0, cmd_accept, irq, dma_req, dma_we, dma_ack, er;
   logic disk_start, head_load, disk_done = 1'b0, disk_err = 1'b0, drive_ready = 1'b1;
   logic [15:0] dma_addr;
   logic [3:0] disk_op;
   logic saw_rst = 1'b0;
   logic [7:0] last_cyl = 8'h00;
   int err_count = 0, n_compared = 0, wt, n_start = 0, eng_cnt = 0, err_mode = 0;
   // -------------------------------------------------------------
   // Design, host memory and clock
   // -------------------------------------------------------------
   fhc_ctrl #(.REV_CYCLES(20)) dut_u (.i_mclk(clk), .i_srst(srst), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .i_cmd_wr(cmd_wr),
      .i_cmd_data(cmd_data), .o_cmd_accept(cmd_accept), .o_irq(irq), .o_dma_req(dma_req),
      .o_dma_we(dma_we), .o_dma_addr(dma_addr), .o_dma_wdata(dma_wdata), .i_dma_ack(dma_ack),
      .i_dma_rdata(dma_rdata), .o_disk_start(disk_start), .o_disk_op(disk_op),
      .o_disk_cyl(disk_cyl), .o_disk_rec(disk_rec), .o_head_load(head_load),
      .i_disk_done(disk_done), .i_disk_err(disk_err), .i_drive_ready(drive_ready),
      .i_xfer_req(1'b0), .i_xfer_we(1'b0), .i_xfer_wdata(8'h00), .o_xfer_ack(),
      .o_xfer_rdata());
   fhc_host_mem mem_u (.i_mclk(clk), .i_dma_req(dma_req), .i_dma_we(dma_we),
      .i_dma_addr(dma_addr), .i_dma_wdata(dma_wdata), .o_dma_ack(dma_ack),
      .o_dma_rdata(dma_rdata));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Disk engine: answers 3 cycles after start, per error mode
   always @(posedge clk) begin
      disk_done <= 1'b0;
      disk_err  <= 1'b0;
      if (disk_start === 1'b1) begin
         eng_cnt  = 3;
         last_cyl = disk_cyl;
         if (disk_op === OP_RESTORE) saw_rst = 1'b1;
         else n_start++;
      end else if (eng_cnt > 0) begin
         eng_cnt--;
         if (eng_cnt == 0 && err_mode == 2 && disk_op !== OP_RESTORE) drive_ready <= 1'b0;
         else if (eng_cnt == 0 && err_mode == 1 && disk_op !== OP_RESTORE) disk_err <= 1'b1;
         else if (eng_cnt == 0) disk_done <= 1'b1;
      end
   end
   // -------------------------------------------------------------
   // Tasks
   // -------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      if (err_count == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      wt = 0;
      do begin @(posedge clk); wt++; end while (pready !== 1'b1 && wt < LIM);
      if (wt >= LIM) err_count++;
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic cmd(input logic [7:0] c);
      cmd_wr   <= 1'b1;
      cmd_data <= c;
      wt = 0;
      do begin @(posedge clk); wt++; end while (cmd_accept !== 1'b1 && wt < LIM);
      if (wt >= LIM) err_count++;
      cmd_wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic run(input logic [15:0] b, input logic [7:0] c, op, rec, input int m);
      mem_u.mem[b[8:0]]        = op;
      mem_u.mem[b[8:0] + 9'h1] = 8'h00;
      mem_u.mem[b[8:0] + 9'h2] = 8'h03;
      mem_u.mem[b[8:0] + 9'h3] = rec;
      mem_u.mem[b[8:0] + 9'h4] = 8'h00;
      mem_u.mem[b[8:0] + 9'h5] = 8'h02;
      err_mode = m;
      n_start  = 0;
      saw_rst  = 1'b0;
      cmd(c);
      wt = 0;
      while (irq !== 1'b1 && wt < LIM) begin @(posedge clk); wt++; end
      if (wt >= LIM) err_count++;
   endtask
   function automatic logic [31:0] stat(input logic [8:0] b);
      return {24'h0, mem_u.mem[b + 9'h1]};
   endfunction
   // -------------------------------------------------------------
   // Main sequence and watchdog
   // -------------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w) chk(rd, rows[i].x);
         chk({31'h0, er}, {31'h0, rows[i].e});
      end
      cmd(8'h00);
      chk(wt, 2);
      chk({31'h0, dma_req}, 32'h0);
      run(16'h0100, 8'h10, 8'h00, REC_MIN, 0);
      chk(stat(9'h100), {24'h0, ST_OK});
      chk({31'h0, saw_rst}, 32'h1);
      chk({31'h0, head_load}, 32'h1);
      repeat (40) @(posedge clk);
      chk({31'h0, head_load}, 32'h0);
      cmd(8'hFF);
      chk({31'h0, irq}, 32'h0);
      run(16'h0180, 8'h12, 8'h00, 8'h05, 1);
      chk(stat(9'h180), {24'h0, ST_HW_FAIL});
      chk(n_start, 11);
      run(16'h0100, 8'h10, 8'h00, REC_MIN, 2);
      chk(stat(9'h100), {24'h0, ST_NOT_READY});
      chk(n_start, 1);
      drive_ready <= 1'b1;
      foreach (args[i]) begin
         run(16'h0100, 8'h10, args[i].op, args[i].rec, 0);
         chk(stat(9'h100), {24'h0, args[i].st});
         if (i == 0) chk({31'h0, saw_rst}, 32'h1);
         if (args[i].st == ST_OK) chk({24'h0, last_cyl}, {24'h0, args[i].cyl});
         if (args[i].st == ST_OK) chk({24'h0, disk_rec}, {24'h0, args[i].rec});
         if (args[i].st == ST_OK) chk({28'h0, disk_op}, {28'h0, args[i].op[7:4]});
      end
      end_sim;
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      end_sim;
   end
endmodule // tb_floppy_host_command_interface
